// ==== tspi_pkg.sv ====
package tspi_pkg;
  localparam int LANES    = 4;
  localparam int CHANS    = 128;
  localparam int CHANNELS = LANES * CHANS;
  localparam int CH_W     = 7;
  localparam int IDX_W    = 9;
  localparam int POS_W    = CH_W + 3;

  // serial-clock samples of steady level before that level counts as idle
  localparam logic [3:0] IDLE_RUN = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] RESET_PAGE = 2'h0;

  typedef enum logic [0:0] {
    TSPI_HUNT   = 1'b0,
    TSPI_LOCKED = 1'b1
  } tspi_sync_t;
endpackage

// ==== tspi_lane.sv ====
`timescale 1ns/1ps
module tspi_lane
  import tspi_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       sample,
  input  wire logic       advance,
  input  wire logic       load,
  input  wire logic [7:0] load_byte,
  input  wire logic       rx,
  output logic      [7:0] rx_byte,
  output logic            tx
);
  typedef struct packed {
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
  } tspi_lane_t;

  tspi_lane_t s;
  tspi_lane_t next_s;

  // byte completes with the bit being sampled right now
  assign rx_byte = {s.rx_sh[6:0], rx};
  assign tx      = s.tx_sh[7];

  always_comb begin
    next_s = s;
    if (sample) begin
      next_s.rx_sh = rx_byte;
    end
    // a channel boundary reloads instead of shifting
    if (load) begin
      next_s.tx_sh = load_byte;
    end else if (advance) begin
      next_s.tx_sh = {s.tx_sh[6:0], 1'b0};
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ==== tspi_top.sv ====
`timescale 1ns/1ps
module tspi_top
  import tspi_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       resetn,
  input  wire logic                       serial_clock,
  input  wire logic                       frame_pulse_in,
  input  wire logic                       frame_eval_or_aux_clock,
  input  wire logic                       wide_frame_select,
  input  wire logic [tspi_pkg::LANES-1:0] serial_in_lanes,
  output logic      [tspi_pkg::LANES-1:0] serial_out_lanes,
  output logic                            serial_out_oe,
  input  wire logic                       serial_out_drive_enable,
  input  wire logic                       output_standby_bit,
  input  wire logic                       bus_style_select,
  input  wire logic                       read_strobe_style,
  input  wire logic                       chip_select_n,
  input  wire logic                       strobe_or_read,
  input  wire logic                       read_write_or_write_n,
  input  wire logic                       addr_strobe_or_latch,
  input  wire logic [7:0]                 host_address_lines,
  input  wire logic [7:0]                 muxed_addr_data_low_in,
  output logic      [7:0]                 muxed_addr_data_low_out,
  output logic                            muxed_addr_data_low_oe,
  input  wire logic [7:0]                 data_high_byte_in,
  output logic      [7:0]                 data_high_byte_out,
  output logic                            data_high_byte_oe,
  output logic                            gci_format,
  output logic                            frame_locked,
  output logic      [tspi_pkg::POS_W-1:0] frame_eval_offset
);
  import tspi_pkg::*;

  typedef struct packed {
    logic                            sclk_d;
    logic                            fe_d;
    logic                            fp_d;
    logic [3:0]                      run;
    logic                            half;
    logic [2:0]                      bit_cnt;
    logic [CH_W-1:0]                 chan;
    tspi_sync_t                      sync;
    logic                            gci;
    logic                            armed;
    logic [POS_W-1:0]                eval_offset;
    logic                            tx_oe;
    logic [7:0]                      addr_lat;
    logic [1:0]                      page;
    logic                            wr_d;
    logic                            host_oe;
    logic [7:0]                      host_dout;
    logic [CHANNELS-1:0][7:0]        data_mem;
    logic [CHANNELS-1:0][IDX_W-1:0]  conn_mem;
  } tspi_state_t;

  tspi_state_t s;
  tspi_state_t next_s;

  logic            sclk_rise;
  logic            aux_rise;
  logic            fstart;
  logic            lock;
  logic            sample;
  logic            advance;
  logic            load;
  logic [CH_W-1:0] next_chan;
  logic [7:0]      addr;
  logic            rd_act;
  logic            wr_act;
  logic [7:0]      rx_byte   [LANES];
  logic [7:0]      load_byte [LANES];

  assign sclk_rise = serial_clock && !s.sclk_d;
  assign aux_rise  = frame_eval_or_aux_clock && !s.fe_d;
  assign lock      = (s.sync == TSPI_LOCKED);

  always_comb begin
    if (wide_frame_select) begin
      // wide pulse: falling edge seen on the auxiliary clock
      fstart = aux_rise && s.fp_d && !frame_pulse_in;
    end else begin
      // standard: any departure from a proven idle level
      fstart = sclk_rise && (s.run >= IDLE_RUN)
               && (frame_pulse_in != s.fp_d);
    end
  end

  // two serial clock rises per bit; second rise samples and shifts
  assign sample    = sclk_rise && lock && s.half && !fstart;
  assign advance   = sample;
  assign load      = fstart || (advance && s.bit_cnt == LAST_BIT);
  assign next_chan = fstart ? '0 : s.chan + 7'h01;

  // non-multiplexed takes the dedicated lines
  assign addr = bus_style_select ? s.addr_lat : host_address_lines;

  always_comb begin
    // strobe polarity depends on style
    if (bus_style_select && read_strobe_style) begin
      rd_act = !chip_select_n && !strobe_or_read;
      wr_act = !chip_select_n && !read_write_or_write_n;
    end else if (bus_style_select) begin
      rd_act = !chip_select_n && strobe_or_read && read_write_or_write_n;
      wr_act = !chip_select_n && strobe_or_read && !read_write_or_write_n;
    end else begin
      rd_act = !chip_select_n && !strobe_or_read && read_write_or_write_n;
      wr_act = !chip_select_n && !strobe_or_read && !read_write_or_write_n;
    end
  end

  // byte for the coming channel is fetched one slot ahead
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      load_byte[l] = s.data_mem[s.conn_mem[{2'(l), next_chan}]];
    end
  end

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    tspi_lane u_lane (
      .clock     (clock),
      .resetn    (resetn),
      .sample    (sample),
      .advance   (advance),
      .load      (load),
      .load_byte (load_byte[g]),
      .rx        (serial_in_lanes[g]),
      .rx_byte   (rx_byte[g]),
      .tx        (serial_out_lanes[g])
    );
  end

  always_comb begin
    next_s        = s;
    next_s.sclk_d = serial_clock;
    next_s.fe_d   = frame_eval_or_aux_clock;
    if (wide_frame_select) begin
      next_s.run = '0;
      if (aux_rise) begin
        next_s.fp_d = frame_pulse_in;
      end
    end else if (sclk_rise) begin
      next_s.fp_d = frame_pulse_in;
      if (frame_pulse_in != s.fp_d) begin
        next_s.run = '0;
      end else if (s.run < IDLE_RUN) begin
        next_s.run = s.run + 4'h1;
      end
      // idle-low pulse stream is the active-high format
      if (s.run >= IDLE_RUN) begin
        next_s.gci = !s.fp_d;
      end
    end
    if (fstart) begin
      next_s.half    = 1'b0;
      next_s.bit_cnt = '0;
      next_s.chan    = '0;
      next_s.sync    = TSPI_LOCKED;
      next_s.armed   = !wide_frame_select;
    end else if (sclk_rise && lock) begin
      next_s.half = !s.half;
      if (s.half) begin
        next_s.bit_cnt = s.bit_cnt + 3'h1;
        if (s.bit_cnt == LAST_BIT) begin
          next_s.chan = s.chan + 7'h01; // wraps at 128
        end
      end
    end
    // measurement pin only meaningful in standard mode
    if (!wide_frame_select && s.armed && !fstart
        && s.fe_d && !frame_eval_or_aux_clock) begin
      next_s.armed       = 1'b0;
      next_s.eval_offset = {s.chan, s.bit_cnt};
    end
    if (sample && s.bit_cnt == LAST_BIT) begin
      for (int l = 0; l < LANES; l++) begin
        next_s.data_mem[{2'(l), s.chan}] = rx_byte[l];
      end
    end
    next_s.tx_oe = serial_out_drive_enable || output_standby_bit;
    if (bus_style_select && addr_strobe_or_latch) begin
      next_s.addr_lat = muxed_addr_data_low_in;
    end
    // write takes effect once, on the strobe's leading edge
    next_s.wr_d = wr_act;
    if (wr_act && !s.wr_d) begin
      next_s.conn_mem[{data_high_byte_in[7:6], addr[6:0]}] =
        {data_high_byte_in[0], muxed_addr_data_low_in};
      next_s.page = data_high_byte_in[7:6];
    end
    next_s.host_oe   = rd_act;
    next_s.host_dout = s.data_mem[{s.page, addr[6:0]}];
  end

  // async clear floats every driver at once
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign serial_out_oe           = s.tx_oe;
  assign muxed_addr_data_low_out = s.host_dout;
  assign muxed_addr_data_low_oe  = s.host_oe;
  assign data_high_byte_out      = 8'h00;
  assign data_high_byte_oe       = s.host_oe;
  assign gci_format              = s.gci;
  assign frame_locked            = lock;
  assign frame_eval_offset       = s.eval_offset;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_tx_float: assert property (
    !serial_out_drive_enable && !output_standby_bit |=> !serial_out_oe)
    else $error("transmit drivers on while disabled");
  a_tx_drive: assert property (
    serial_out_drive_enable |=> serial_out_oe)
    else $error("transmit drivers off while enabled");
  a_bit_hold: assert property (
    lock && sclk_rise && !s.half && !fstart
    |=> s.bit_cnt == $past(s.bit_cnt))
    else $error("bit advanced on first serial clock");
  a_bit_step: assert property (
    sample |=> s.bit_cnt == $past(s.bit_cnt) + 3'h1)
    else $error("bit did not advance on second serial clock");
  a_chan_wrap: assert property (
    sample && s.bit_cnt == 3'h7 && s.chan == 7'h7f |=> s.chan == 7'h00)
    else $error("channel count not 128 per frame");
  a_rx_store: assert property (
    sample && s.bit_cnt == 3'h7
    |=> s.data_mem[{2'b00, $past(s.chan)}] == $past(rx_byte[0]))
    else $error("received byte not stored");
  a_wide_sync: assert property (
    wide_frame_select && aux_rise && s.fp_d && !frame_pulse_in
    |=> lock && s.chan == 7'h00 && s.bit_cnt == 3'h0 && !s.half)
    else $error("wide frame pulse not aligned");
  a_std_sync: assert property (
    !wide_frame_select && sclk_rise && s.run >= IDLE_RUN
    && frame_pulse_in != s.fp_d |=> lock && s.chan == 7'h00)
    else $error("standard frame pulse not aligned");
  a_eval_cap: assert property (
    !wide_frame_select && s.armed && !fstart && s.fe_d
    && !frame_eval_or_aux_clock
    |=> !s.armed && s.eval_offset == $past({s.chan, s.bit_cnt}))
    else $error("frame evaluation edge not captured");
  a_host_read: assert property (
    bus_style_select && read_strobe_style && !chip_select_n
    && !strobe_or_read |=> muxed_addr_data_low_oe)
    else $error("data lines not driven during read");
endmodule

// ==== tspi_far_end.sv ====
`timescale 1ns/1ps
module tspi_far_end
  import tspi_pkg::*;
(
  input  wire logic        polarity,
  input  wire logic        wide,
  input  wire logic [7:0]  salt,
  input  wire logic [9:0]  eval_at,
  input  wire logic [3:0]  tx,
  output logic             sclk,
  output logic             fpulse,
  output logic             fe,
  output logic      [3:0]  rx,
  output logic      [10:0] rise_count,
  output logic      [31:0] tx_cap
);
  int     j;
  logic [7:0] v;

  // period shortened to 32 ns so that four frames fit the run
  initial begin
    sclk = 1'b0;
    fe = 1'b1;
    rx = 4'h0;
    fpulse = ~polarity;
    rise_count = 11'h7d0;
    tx_cap = 32'h0000_0000;
    #1;
    forever #16 sclk = ~sclk;
  end

  always @(posedge sclk) begin
    rise_count <= (rise_count == 11'h7ff) ? 11'h000 : rise_count + 11'h001;
  end

  always @(negedge sclk) begin
    if (wide) begin
      // low across the aux rise that opens the frame
      fpulse <= !(rise_count == 11'h7ff || rise_count == 11'h000);
      // aux clock at a quarter of the serial clock
      fe <= ~rise_count[1];
    end else begin
      // pulse straddles the rise that opens the frame
      fpulse <= (rise_count == 11'h7ff) ? polarity : ~polarity;
      if (rise_count == 11'h000) begin
        fe <= 1'b1;
      end else if (rise_count == {1'b0, eval_at}) begin
        fe <= 1'b0;
      end
    end
    if (!rise_count[0] || rise_count == 11'h7ff) begin
      j = rise_count[0] ? 0 : int'(rise_count) / 2;
      for (int l = 0; l < 4; l++) begin
        v = 8'(j / 8) ^ 8'(l << 5) ^ salt;
        rx[l] <= v[7 - j % 8];
      end
    end
    if (rise_count[0]) begin
      for (int l = 0; l < 4; l++) begin
        tx_cap[l*8 +: 8] <= {tx_cap[l*8 +: 7], tx[l]};
      end
    end
  end
endmodule

// ==== tdm_switch_pin_interface_tb_top.sv ====
`timescale 1ns/1ps
module tdm_switch_pin_interface_tb_top;
  import tspi_pkg::*;
  logic        clock, resetn, pol, de, sb, bss, rss, cs_n, sor, rw, ale;
  logic        sclk, fp, fe, tx_oe, ad_oe, hi_oe, gci, locked, wfs;
  logic [7:0]  salt, addr_in, ad_in, hi_in, ad_out, hi_out, rd;
  logic [9:0]  eval_at, feo;
  logic [3:0]  rx, tx;
  logic [10:0] rc;
  logic [31:0] cap;
  int          err_count, comparisons, cycles, seed, l, c, l2, c2, a;
  int          conn[512];

  tspi_top i_tspi_top (.clock(clock), .resetn(resetn), .serial_clock(sclk),
    .frame_pulse_in(fp), .frame_eval_or_aux_clock(fe),
    .wide_frame_select(wfs), .serial_in_lanes(rx), .serial_out_lanes(tx),
    .serial_out_oe(tx_oe), .serial_out_drive_enable(de),
    .output_standby_bit(sb), .bus_style_select(bss),
    .read_strobe_style(rss), .chip_select_n(cs_n), .strobe_or_read(sor),
    .read_write_or_write_n(rw), .addr_strobe_or_latch(ale),
    .host_address_lines(addr_in), .muxed_addr_data_low_in(ad_in),
    .muxed_addr_data_low_out(ad_out), .muxed_addr_data_low_oe(ad_oe),
    .data_high_byte_in(hi_in), .data_high_byte_out(hi_out),
    .data_high_byte_oe(hi_oe), .gci_format(gci), .frame_locked(locked),
    .frame_eval_offset(feo));

  tspi_far_end i_tspi_far_end (.polarity(pol), .wide(wfs), .salt(salt),
    .eval_at(eval_at), .tx(tx), .sclk(sclk), .fpulse(fp), .fe(fe),
    .rx(rx), .rise_count(rc), .tx_cap(cap));

  function automatic logic [7:0] model_byte(input int ln, input int ch);
    return 8'(ch) ^ 8'(ln << 5) ^ salt;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic idle(input int m);
    cs_n = 1'b1;
    bss = (m != 0);
    rss = (m == 2);
    sor = (m != 1);
    rw = 1'b1;
    ale = 1'b0;
  endtask

  // one access; mode 0 plain, 1 muxed data strobe, 2 muxed read strobe
  task automatic host(input int m, input bit wr, input logic [7:0] ad,
                      input logic [15:0] d);
    @(negedge clock);
    idle(m);
    addr_in = ad;
    ad_in = ad;
    ale = (m != 0);
    @(negedge clock);
    ale = 1'b0;
    ad_in = d[7:0];
    hi_in = d[15:8];
    cs_n = 1'b0;
    if (wr) rw = 1'b0;
    if (!wr || m != 2) sor = (m == 1);
    repeat (2) @(negedge clock);
    rd = ad_out;
    check({hi_oe, ad_oe, hi_out}, {{2{~wr}}, 8'h00});
    idle(m);
    repeat (2) @(negedge clock);
    check({hi_oe, ad_oe}, 2'b00);
  endtask

  task automatic wait_rise(input int v);
    do @(negedge sclk); while (rc != 11'(v));
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    seed = 32'h7973_f201;
    salt = 8'($random(seed));
    eval_at = 10'(({$random(seed)} % 500) * 2 + 2);
    resetn = 1'b0;
    wfs = 1'b0;
    pol = 1'b1;
    {de, sb, addr_in, ad_in, hi_in} = 26'h000_0000;
    idle(0);
    repeat (26) @(negedge clock);
    check({tx_oe, ad_oe, hi_oe, locked, feo}, 14'h0000);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {de, sb} = 2'(i);
      repeat (2) @(negedge clock);
      check(tx_oe, de | sb);
    end
    wait_rise(1);
    check({locked, gci}, 2'b11);
    resetn = 1'b0;
    pol = 1'b0;
    repeat (26) @(negedge clock);
    resetn = 1'b1;
    wait_rise(1);
    check({locked, gci}, 2'b10);
    wait_rise(int'(eval_at) + 3);
    check(feo, eval_at >> 1);
    wait_rise(1);
    // muxed and plain host styles each program one connection
    for (int m = 0; m < 3; m++) begin
      l = {$random(seed)} % 4;
      c = {$random(seed)} % 127;
      l2 = {$random(seed)} % 4;
      c2 = {$random(seed)} % 127;
      a = {$random(seed)} % 127;
      host(m, 1'b1, 8'(c), {2'(l), 5'h00, 2'(l2), 7'(c2)});
      conn[l*128 + c] = l2 * 128 + c2;
      host(m, 1'b0, 8'(a), 16'h0000);
      check(rd, model_byte(l, a));
    end
    wait_rise(1);
    // channel 127 skipped: its last bit shares the frame-start rise
    for (int ch = 0; ch < 127; ch++) begin
      wait_rise(16 * ch + 15);
      #1;
      for (int ln = 0; ln < 4; ln++) begin
        a = conn[ln*128 + ch];
        check(cap[ln*8 +: 8], model_byte(a / 128, a % 128));
      end
    end
    // lock now depends on the wide pulse alone
    @(negedge clock);
    resetn = 1'b0;
    wfs = 1'b1;
    repeat (26) @(negedge clock);
    resetn = 1'b1;
    check({locked, feo}, 11'h000);
    wait_rise(1);
    check({locked, feo}, 11'h400);
    // memories cleared: every output sources lane 0 channel 0, stored
    // one slot too late for channels 0 and 1 of this frame
    for (int ch = 2; ch < 10; ch++) begin
      wait_rise(16 * ch + 15);
      #1;
      for (int ln = 0; ln < 4; ln++) begin
        check(cap[ln*8 +: 8], model_byte(0, 0));
      end
    end
    close_out();
  end
endmodule
